// >>> design/sfr_core.sv
// Register bank, machine-cycle engine and timers of the 4-clock core
//
// What this block does
// RQ1 - A machine cycle lasts four clocks, not twelve.
// RQ2 - Exactly one address-latch strobe pulse in every machine cycle.
// RQ3 - Timers tick every twelve clocks after reset; each selectable to four.
// RQ4 - External data move takes two cycles; direct-to-direct move three.
// RQ5 - One machine cycle per instruction byte by default.
// RQ6 - Instructions take one to five machine cycles.
// RQ7 - Flags and status update as the legacy instruction set defines.
// RQ8 - All legacy registers live at their legacy addresses with new ones.
// RQ9 - One-cycle instruction finishes in 121 ns at top clock rate; here it takes four clocks, 400 ns at the 100 ns clock period.
// RQ10 - Fully static logic; keeps state with clock stopped.
// RQ11 - No counter array unit; its addresses stay unimplemented.
// RQ12 - Fixed-zero bits read zero; writes to them do nothing.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module sfr_core (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Core timing outputs
  output logic             addr_latch_strobe,
  output logic             ins_done,
  output logic             timer_tick0,
  output logic             timer_tick1,
  output logic             timer_tick2
);
  // Register storage indexed by low address bits
  logic [7:0] sfr_q [0:255];
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [7:0] rd_addr;
  logic [8:0] rd_mask;
  logic [8:0] wr_mask;
  logic       take;
  // Cycle engine state
  typedef enum logic [1:0] {st_idle, st_run} eng_t;
  eng_t       eng_q;
  logic [1:0] phase_q;
  logic [2:0] cyc_left_q;
  logic [2:0] cyc_total_q;
  logic       ins_req_q;
  sfr_pkg::ins_req_t req_q;
  // Timer prescalers
  logic [3:0] pre_q [0:2];
  logic       tick_q [0:2];
  logic [2:0] fast_sel;
  logic [2:0] run_sel;

  // Mask of writable bits per address, also the implemented set
  function automatic logic [8:0] reg_mask(input logic [7:0] a);
    case (a)
      sfr_pkg::pointer_choice_addr:   reg_mask = {1'b1, sfr_pkg::pointer_choice_mask};
      sfr_pkg::rom_size_select_addr:  reg_mask = {1'b1, sfr_pkg::rom_size_select_mask};
      sfr_pkg::timer2_mode_addr:      reg_mask = {1'b1, sfr_pkg::timer2_mode_mask};
      sfr_pkg::ext_irq_enable_addr:   reg_mask = {1'b1, sfr_pkg::ext_irq_enable_mask};
      sfr_pkg::irq_rank_addr:         reg_mask = {1'b1, sfr_pkg::irq_rank_mask};
      sfr_pkg::alarm_seconds_addr,
      sfr_pkg::alarm_minutes_addr:    reg_mask = {1'b1, sfr_pkg::alarm_sec_min_mask};
      sfr_pkg::power_control_addr:    reg_mask = {1'b1, sfr_pkg::power_control_mask};
      sfr_pkg::power_management_addr: reg_mask = {1'b1, sfr_pkg::power_management_mask};
      sfr_pkg::core_flags_addr,
      sfr_pkg::cycle_status_addr:     reg_mask = 9'h100;
      sfr_pkg::port0_latch_addr, sfr_pkg::push_pop_pointer_addr,
      sfr_pkg::move_pointer0_low_addr, sfr_pkg::move_pointer0_high_addr,
      sfr_pkg::move_pointer1_low_addr, sfr_pkg::move_pointer1_high_addr,
      sfr_pkg::timer_control_addr, sfr_pkg::timer_mode_addr,
      sfr_pkg::timer0_low_addr, sfr_pkg::timer1_low_addr,
      sfr_pkg::timer0_high_addr, sfr_pkg::timer1_high_addr,
      sfr_pkg::clock_control_addr, sfr_pkg::port1_latch_addr,
      sfr_pkg::external_irq_flags_addr, sfr_pkg::rtc_oscillator_trim_addr,
      sfr_pkg::serial0_control_addr, sfr_pkg::serial0_buffer_addr,
      sfr_pkg::port2_latch_addr, sfr_pkg::irq_enable_addr,
      sfr_pkg::serial0_slave_addr_addr, sfr_pkg::serial1_slave_addr_addr,
      sfr_pkg::port3_latch_addr, sfr_pkg::serial0_addr_mask_addr,
      sfr_pkg::serial1_addr_mask_addr, sfr_pkg::serial1_control_addr,
      sfr_pkg::serial1_buffer_addr, sfr_pkg::timed_access_addr,
      sfr_pkg::timer2_control_addr, sfr_pkg::timer2_capture_low_addr,
      sfr_pkg::timer2_capture_high_addr, sfr_pkg::timer2_low_addr,
      sfr_pkg::timer2_high_addr, sfr_pkg::program_flags_word_addr,
      sfr_pkg::watchdog_control_addr, sfr_pkg::main_working_reg_addr,
      sfr_pkg::second_operand_addr, sfr_pkg::alarm_subseconds_addr,
      sfr_pkg::cycle_request_addr:    reg_mask = 9'h1FF;
      default:                        reg_mask = 9'h000;
    endcase
  endfunction

  // Reset value per address; ports idle high as in the legacy part
  function automatic logic [7:0] reset_val(input int a);
    case (a)
      32'(sfr_pkg::port0_latch_addr), 32'(sfr_pkg::port1_latch_addr),
      32'(sfr_pkg::port2_latch_addr), 32'(sfr_pkg::port3_latch_addr):
        reset_val = sfr_pkg::port_reset_val;
      32'(sfr_pkg::push_pop_pointer_addr):
        reset_val = sfr_pkg::stack_reset_val;
      default:
        reset_val = sfr_pkg::reg_reset_val;
    endcase
  endfunction

  // Transfer taken in address phase; write lands in next (data) phase
  assign take    = hsel && hready && htrans[1];
  // One register per word: the register index is the word address
  assign rd_addr = haddr[9:2];
  // Anything above the 256-word window decodes as unimplemented
  assign rd_mask = (haddr[31:10] == 22'h000000) ? reg_mask(rd_addr)
                                                 : 9'h000;
  assign wr_mask = reg_mask(wr_addr_q);

  // Address phase capture for writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= take && hwrite && rd_mask[8];
      wr_addr_q <= rd_addr;
    end
  end

  // Zero-wait slave, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data registered in address phase; counter array space reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (take && !hwrite) begin
      if (!rd_mask[8]) begin
        hrdata <= 32'h00000000; // RQ11
      end else if (rd_addr == sfr_pkg::core_flags_addr) begin
        hrdata <= {24'h000000, 1'b0, eng_q == st_run, 3'b000,
                   cyc_total_q}; // RQ6
      end else if (rd_addr == sfr_pkg::cycle_status_addr) begin
        hrdata <= {24'h000000, phase_q, 3'b000, cyc_left_q};
      end else begin
        hrdata <= {24'h000000, sfr_q[rd_addr] & rd_mask[7:0]}; // RQ12
      end
    end
  end

  // Register array, legacy addresses kept; static storage
  generate
    for (genvar g = 0; g < 256; g++) begin : g_reg
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sfr_q[g] <= reset_val(g); // RQ8 RQ10
        end else if (wr_pend_q && wr_addr_q == 8'(g)) begin
          sfr_q[g] <= hwdata[7:0] & wr_mask[7:0]; // RQ12 RQ7
        end
      end
    end
  endgenerate

  // Instruction request: write of cycle_request starts one instruction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ins_req_q <= 1'b0;
      req_q     <= '0;
    end else begin
      ins_req_q <= wr_pend_q && wr_addr_q == sfr_pkg::cycle_request_addr;
      req_q     <= sfr_pkg::ins_req_t'({hwdata[4:3], hwdata[2:0]});
    end
  end

  // Cycle count from class and length
  function automatic logic [2:0] cycles_of(input sfr_pkg::ins_req_t r);
    logic [2:0] n;
    n = 3'(sfr_pkg::min_cycles);
    unique case (r.cls)
      sfr_pkg::ins_ext_move:    n = 3'(sfr_pkg::ext_move_cycles);    // RQ4
      sfr_pkg::ins_direct_move: n = 3'(sfr_pkg::direct_move_cycles); // RQ4
      sfr_pkg::ins_long:        n = 3'(sfr_pkg::max_cycles);         // RQ6
      sfr_pkg::ins_by_length: begin
        n = r.length; // RQ5
      end
    endcase
    if (n < 3'(sfr_pkg::min_cycles)) n = 3'(sfr_pkg::min_cycles); // RQ6
    if (n > 3'(sfr_pkg::max_cycles)) n = 3'(sfr_pkg::max_cycles); // RQ6
    cycles_of = n;
  endfunction

  // Free-running four-clock machine cycle phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= 2'(phase_q + 2'h1); // RQ1 RQ9
    end
  end

  // One strobe per machine cycle, at phase zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_latch_strobe <= 1'b0;
    end else begin
      addr_latch_strobe <= (phase_q == 2'h3); // RQ2
    end
  end

  // Execution engine: counts machine cycles of one instruction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eng_q       <= st_idle;
      cyc_left_q  <= 3'h0;
      cyc_total_q <= 3'h0;
      ins_done    <= 1'b0;
    end else begin
      ins_done <= 1'b0;
      unique case (eng_q)
        st_idle: begin
          if (ins_req_q) begin
            eng_q       <= st_run;
            cyc_left_q  <= cycles_of(req_q);
            cyc_total_q <= cycles_of(req_q);
          end
        end
        st_run: begin
          if (phase_q == 2'h3) begin
            if (cyc_left_q == 3'h1) begin
              eng_q    <= st_idle;
              ins_done <= 1'b1; // RQ4 RQ6
            end
            cyc_left_q <= 3'(cyc_left_q - 3'h1);
          end
        end
      endcase
    end
  end

  // Timer rate select and run bits
  assign fast_sel = {sfr_q[sfr_pkg::clock_control_addr][sfr_pkg::timer2_fast_pos],
                     sfr_q[sfr_pkg::clock_control_addr][sfr_pkg::timer1_fast_pos],
                     sfr_q[sfr_pkg::clock_control_addr][sfr_pkg::timer0_fast_pos]};
  assign run_sel  = {sfr_q[sfr_pkg::timer2_control_addr][sfr_pkg::timer2_run_pos],
                     sfr_q[sfr_pkg::timer_control_addr][sfr_pkg::timer1_run_pos],
                     sfr_q[sfr_pkg::timer_control_addr][sfr_pkg::timer0_run_pos]};

  // Per-timer prescaler: 12 clocks by default, 4 when fast selected
  // A switch to fast with the count past three wraps once: one long gap
  generate
    for (genvar t = 0; t < 3; t++) begin : g_tmr
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pre_q[t]  <= 4'h0;
          tick_q[t] <= 1'b0;
        end else if (!run_sel[t]) begin
          pre_q[t]  <= 4'h0;
          tick_q[t] <= 1'b0;
        end else if (pre_q[t] == (fast_sel[t]
                     ? 4'(sfr_pkg::fast_timer_clocks - 1)
                     : 4'(sfr_pkg::legacy_timer_clocks - 1))) begin
          pre_q[t]  <= 4'h0;
          tick_q[t] <= 1'b1; // RQ3
        end else begin
          pre_q[t]  <= 4'(pre_q[t] + 4'h1);
          tick_q[t] <= 1'b0;
        end
      end
    end
  endgenerate

  // Tick outputs straight from flip-flops
  assign timer_tick0 = tick_q[0];
  assign timer_tick1 = tick_q[1];
  assign timer_tick2 = tick_q[2];

  // Strobe spacing: exactly four clocks apart
  strobe_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_latch_strobe |-> ##1 !addr_latch_strobe [*3] ##1 addr_latch_strobe)
    else $error("strobe not once per four clocks"); // RQ2

  // Phase advances by one every clock
  phase_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) |-> phase_q == 2'($past(phase_q) + 2'h1))
    else $error("machine cycle phase skipped"); // RQ1

  // Legacy timer tick spacing of twelve clocks
  legacy_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick_q[0] && !fast_sel[0] && run_sel[0]) |=> ##11
      ((tick_q[0] == 1'b1) || !run_sel[0] || fast_sel[0]
       || !$stable(fast_sel[0])))
    else $error("timer0 legacy rate wrong"); // RQ3

  // Fast timer tick four clocks later
  fast_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick_q[1] && fast_sel[1] && run_sel[1]) ##1
      (fast_sel[1] && run_sel[1]) [*3] |=> tick_q[1])
    else $error("timer1 fast rate wrong"); // RQ3

  // External move: two machine cycles, the first one partial, done on a boundary
  ext_move_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (eng_q == st_idle && ins_req_q && req_q.cls == sfr_pkg::ins_ext_move)
      |-> ##[6:9] ins_done)
    else $error("external move length wrong"); // RQ4

  // Direct move: three machine cycles, the first one partial, done on a boundary
  direct_move_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (eng_q == st_idle && ins_req_q && req_q.cls == sfr_pkg::ins_direct_move)
      |-> ##[10:13] ins_done)
    else $error("direct move length wrong"); // RQ4

  // Cycle count stays within one to five
  cycle_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
    eng_q == st_run |-> cyc_total_q >= 3'h1 && cyc_total_q <= 3'h5)
    else $error("instruction cycles out of range"); // RQ6

  // Unmapped and counter array reads return zero
  unmapped_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && !rd_mask[8]) |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero"); // RQ11

  // Fixed-zero bits of pointer choice never set
  fixed_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (sfr_q[sfr_pkg::pointer_choice_addr] & ~sfr_pkg::pointer_choice_mask)
      == 8'h00)
    else $error("fixed zero bit set"); // RQ12

  // By-length instruction takes its byte count in cycles
  by_length_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (eng_q == st_idle && ins_req_q && req_q.cls == sfr_pkg::ins_by_length
     && req_q.length == 3'h3) |=> cyc_total_q == 3'h3)
    else $error("length to cycles mismatch"); // RQ5

  // Request while busy leaves the running count alone
  busy_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (ins_req_q && eng_q == st_run) |=> cyc_total_q == $past(cyc_total_q))
    else $error("request taken while busy"); // RQ6

  // Long class always runs five machine cycles
  long_ins_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (eng_q == st_idle && ins_req_q && req_q.cls == sfr_pkg::ins_long)
      |=> cyc_total_q == 3'h5)
    else $error("long instruction length wrong"); // RQ6

  // Cycles left never exceed the total and never hit zero while running
  cycles_left_a: assert property (@(posedge hclk) disable iff (!hresetn)
    eng_q == st_run |-> cyc_left_q <= cyc_total_q && cyc_left_q != 3'h0)
    else $error("cycles left out of range"); // RQ6

  // Completion pulse lasts one clock
  done_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ins_done |=> !ins_done)
    else $error("completion pulse too long"); // RQ6

  // Completion lands on a machine cycle boundary
  done_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ins_done |-> addr_latch_strobe)
    else $error("completion off cycle boundary"); // RQ1

  // Stopped timer gives no tick
  timer_halt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !run_sel[0] |=> !tick_q[0])
    else $error("stopped timer0 ticked"); // RQ3

  // Fast timer2 ticks four clocks apart
  fast_tick2_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (tick_q[2] && fast_sel[2] && run_sel[2]) ##1
      (fast_sel[2] && run_sel[2]) [*3] |=> tick_q[2])
    else $error("timer2 fast rate wrong"); // RQ3
endmodule

// >>> design/sfr_pkg.sv
// Register map, field positions, timing counts and carriers of the core
package sfr_pkg;
  // Register word addresses on the AHB-Lite slave (haddr[9:2])
  localparam logic [7:0] port0_latch_addr         = 8'h80;
  localparam logic [7:0] push_pop_pointer_addr    = 8'h81;
  localparam logic [7:0] move_pointer0_low_addr   = 8'h82;
  localparam logic [7:0] move_pointer0_high_addr  = 8'h83;
  localparam logic [7:0] move_pointer1_low_addr   = 8'h84;
  localparam logic [7:0] move_pointer1_high_addr  = 8'h85;
  localparam logic [7:0] pointer_choice_addr      = 8'h86;
  localparam logic [7:0] power_control_addr       = 8'h87;
  localparam logic [7:0] timer_control_addr       = 8'h88;
  localparam logic [7:0] timer_mode_addr          = 8'h89;
  localparam logic [7:0] timer0_low_addr          = 8'h8A;
  localparam logic [7:0] timer1_low_addr          = 8'h8B;
  localparam logic [7:0] timer0_high_addr         = 8'h8C;
  localparam logic [7:0] timer1_high_addr         = 8'h8D;
  localparam logic [7:0] clock_control_addr       = 8'h8E;
  localparam logic [7:0] port1_latch_addr         = 8'h90;
  localparam logic [7:0] external_irq_flags_addr  = 8'h91;
  localparam logic [7:0] rtc_oscillator_trim_addr = 8'h96;
  localparam logic [7:0] serial0_control_addr     = 8'h98;
  localparam logic [7:0] serial0_buffer_addr      = 8'h99;
  localparam logic [7:0] port2_latch_addr         = 8'hA0;
  localparam logic [7:0] irq_enable_addr          = 8'hA8;
  localparam logic [7:0] serial0_slave_addr_addr  = 8'hA9;
  localparam logic [7:0] serial1_slave_addr_addr  = 8'hAA;
  localparam logic [7:0] port3_latch_addr         = 8'hB0;
  localparam logic [7:0] irq_rank_addr            = 8'hB8;
  localparam logic [7:0] serial0_addr_mask_addr   = 8'hB9;
  localparam logic [7:0] serial1_addr_mask_addr   = 8'hBA;
  localparam logic [7:0] serial1_control_addr     = 8'hC0;
  localparam logic [7:0] serial1_buffer_addr      = 8'hC1;
  localparam logic [7:0] rom_size_select_addr     = 8'hC2;
  localparam logic [7:0] power_management_addr    = 8'hC4;
  localparam logic [7:0] core_flags_addr          = 8'hC5;
  localparam logic [7:0] timed_access_addr        = 8'hC7;
  localparam logic [7:0] timer2_control_addr      = 8'hC8;
  localparam logic [7:0] timer2_mode_addr         = 8'hC9;
  localparam logic [7:0] timer2_capture_low_addr  = 8'hCA;
  localparam logic [7:0] timer2_capture_high_addr = 8'hCB;
  localparam logic [7:0] timer2_low_addr          = 8'hCC;
  localparam logic [7:0] timer2_high_addr         = 8'hCD;
  localparam logic [7:0] program_flags_word_addr  = 8'hD0;
  localparam logic [7:0] watchdog_control_addr    = 8'hD8;
  localparam logic [7:0] main_working_reg_addr    = 8'hE0;
  localparam logic [7:0] ext_irq_enable_addr      = 8'hE8;
  localparam logic [7:0] second_operand_addr      = 8'hF0;
  localparam logic [7:0] alarm_subseconds_addr    = 8'hF2;
  localparam logic [7:0] alarm_seconds_addr       = 8'hF3;
  localparam logic [7:0] alarm_minutes_addr       = 8'hF4;
  // Own registers: cycle engine control and status
  localparam logic [7:0] cycle_request_addr       = 8'h70;
  localparam logic [7:0] cycle_status_addr        = 8'h74;
  // Writable-bit masks; zero bits are fixed zero
  localparam logic [7:0] pointer_choice_mask      = 8'h01;
  localparam logic [7:0] rom_size_select_mask     = 8'h07;
  localparam logic [7:0] timer2_mode_mask         = 8'h03;
  localparam logic [7:0] ext_irq_enable_mask      = 8'h3F;
  localparam logic [7:0] irq_rank_mask            = 8'h7F;
  localparam logic [7:0] alarm_sec_min_mask       = 8'h3F;
  localparam logic [7:0] power_control_mask       = 8'hCF;
  localparam logic [7:0] power_management_mask    = 8'hEF;
  // Field positions
  localparam int timer0_fast_pos     = 3;
  localparam int timer1_fast_pos     = 4;
  localparam int timer2_fast_pos     = 5;
  localparam int timer0_run_pos      = 4;
  localparam int timer1_run_pos      = 6;
  localparam int timer2_run_pos      = 2;
  localparam int timer0_ovf_pos      = 5;
  localparam int timer1_ovf_pos      = 7;
  localparam int timer2_ovf_pos      = 7;
  // Reset values
  localparam logic [7:0] reg_reset_val      = 8'h00;
  localparam logic [7:0] port_reset_val     = 8'hFF;
  localparam logic [7:0] stack_reset_val    = 8'h07;
  // Timing counts
  localparam int clocks_per_cycle      = 4;
  localparam int legacy_timer_clocks   = 12;
  localparam int fast_timer_clocks     = 4;
  localparam int min_cycles            = 1;
  localparam int max_cycles            = 5;
  localparam int ext_move_cycles       = 2;
  localparam int direct_move_cycles    = 3;
  localparam int single_cycle_ns       = 121;
  localparam int clk_period_ns         = 100;
  // Clocks a one-cycle instruction needs at the block's own rate
  localparam int single_cycle_clocks   = clocks_per_cycle;
  // Instruction classes of the cycle engine
  typedef enum logic [1:0] {
    ins_by_length,
    ins_ext_move,
    ins_direct_move,
    ins_long
  } ins_class_t;
  // Request that the cycle engine takes
  typedef struct packed {
    ins_class_t cls;
    logic [2:0] length;
  } ins_req_t;
endpackage

// >>> tb/tb_sfr_core.sv
// Self-checking bench: register map, cycle timing and timer tick rates
`timescale 1ns/10ps
module tb_sfr_core;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        addr_latch_strobe;
  logic        ins_done;
  logic        timer_tick0;
  logic        timer_tick1;
  logic        timer_tick2;
  int          fail_count;
  int          checks_done;
  int          cyc;
  int          cnt[5];
  int          last_t[5];
  int          gap[5];
  logic [31:0] rd;
  logic [4:0]  pulses;

  sfr_core uut (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .hsel              (hsel),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (hsize),
    .hwdata            (hwdata),
    .hready            (hreadyout),
    .hrdata            (hrdata),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .addr_latch_strobe (addr_latch_strobe),
    .ins_done          (ins_done),
    .timer_tick0       (timer_tick0),
    .timer_tick1       (timer_tick1),
    .timer_tick2       (timer_tick2)
  );

  // 10 MHz clock
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Pulse counts and spacing, sampled before the edge's own updates land
  assign pulses = {timer_tick2, timer_tick1, timer_tick0, ins_done,
                   addr_latch_strobe};
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 5; i++) begin
      if (pulses[i] === 1'b1) begin
        cnt[i]    <= cnt[i] + 1;
        gap[i]    <= cyc - last_t[i];
        last_t[i] <= cyc;
      end
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One AHB-Lite single word transfer; registers sit one per word
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] val);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h000000, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h000000, val};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask

  task automatic wr_rd(input logic [7:0] idx, input logic [7:0] val,
                       input logic [7:0] exp);
    bus(1'b1, idx, val);
    bus(1'b0, idx, 8'h00);
    check($sformatf("reg %h", idx), {24'h000000, exp}, rd);
  endtask

  // Timer spacing for all three timers against the expected clocks each
  task automatic timer_gaps(input int e0, input int e1, input int e2);
    repeat (40) @(posedge hclk);
    check("timer0 gap", e0, gap[2]);
    check("timer1 gap", e1, gap[3]);
    check("timer2 gap", e2, gap[4]);
  endtask

  // Cycle engine request; ins_done must land within three clocks of n machine cycles
  task automatic run_ins(input logic [7:0] code, input int n);
    int c0;
    int k0;
    int el;
    bus(1'b1, sfr_pkg::cycle_request_addr, code);
    c0 = cyc;
    k0 = cnt[1];
    for (int i = 0; i < 60 && cnt[1] == k0; i++) @(posedge hclk);
    @(posedge hclk);
    el = last_t[1] - c0;
    check($sformatf("done count %h", code), k0 + 1, cnt[1]);
    if (el < 4 * n - 3 || el > 4 * n + 3) begin
      fail_count++;
      $display("mismatch ins %h expected %0d clocks seen %0d", code,
               4 * n, el);
    end
    checks_done++;
    repeat (8) @(posedge hclk);
  endtask

  // Watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    #(100 * 20000);
    fail_count++;
    stop_test();
  end

  initial begin
    int k;
    logic [7:0] plain [11] = '{8'h81, 8'h82, 8'h85, 8'h89, 8'h99, 8'hA9,
                               8'hCB, 8'hD0, 8'hE0, 8'hF0, 8'hF2};
    logic [7:0] midx [8] = '{8'h86, 8'hC2, 8'hC9, 8'hE8, 8'hB8, 8'hF3,
                             8'hF4, 8'hC4};
    logic [7:0] mval [8] = '{8'h01, 8'h07, 8'h03, 8'h3F, 8'h7F, 8'h3F,
                             8'h3F, 8'hEF};
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    fail_count = 0;
    checks_done = 0;
    cyc = 0;
    for (int i = 0; i < 5; i++) begin
      cnt[i] = 0;
      last_t[i] = 0;
      gap[i] = 0;
    end
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values of ports and stack pointer
    foreach (midx[i]) begin
      bus(1'b0, 8'h80 + 8'(i % 4) * 8'h10, 8'h00);
      if (i < 4) check("port reset", 32'h000000FF, rd);
    end
    bus(1'b0, sfr_pkg::push_pop_pointer_addr, 8'h00);
    check("stack reset", 32'h00000007, rd);
    // Strobe: one per four clocks, back to back
    k = cnt[0];
    repeat (40) @(posedge hclk);
    check("strobe count", k + 10, cnt[0]);
    check("strobe gap", 4, gap[0]);
    // Timers start at twelve clocks; timer0 switches to four alone, then timer1 and timer2 together as timer0 goes back to twelve
    bus(1'b1, sfr_pkg::timer_control_addr, 8'h50);
    bus(1'b1, sfr_pkg::timer2_control_addr, 8'h04);
    timer_gaps(12, 12, 12);
    bus(1'b1, sfr_pkg::clock_control_addr, 8'h08);
    timer_gaps(4, 12, 12);
    bus(1'b1, sfr_pkg::clock_control_addr, 8'h30);
    timer_gaps(12, 4, 4);
    // Instruction lengths, clamps and the fixed-length classes
    run_ins(8'h01, 1);
    run_ins(8'h03, 3);
    run_ins(8'h05, 5);
    run_ins(8'h07, 5);
    run_ins(8'h00, 1);
    run_ins(8'h08, 2);
    run_ins(8'h10, 3);
    run_ins(8'h18, 5);
    // Request while busy is dropped: only one completion follows
    bus(1'b1, sfr_pkg::cycle_request_addr, 8'h18);
    bus(1'b1, sfr_pkg::cycle_request_addr, 8'h18);
    // Busy flag and cycle total of the running long instruction
    bus(1'b0, sfr_pkg::core_flags_addr, 8'h00);
    check("busy flags", 32'h00000045, rd);
    k = cnt[1];
    repeat (60) @(posedge hclk);
    check("busy drop", k + 1, cnt[1]);
    // Plain registers hold every bit
    foreach (plain[i]) begin
      wr_rd(plain[i], 8'hFF, 8'hFF);
      wr_rd(plain[i], 8'h5A, 8'h5A);
    end
    // Fixed-zero bits stay zero
    foreach (midx[i]) begin
      wr_rd(midx[i], 8'hFF, mval[i]);
      wr_rd(midx[i], 8'h00, 8'h00);
    end
    // Counter array and gaps in the map stay empty
    wr_rd(8'hD9, 8'hFF, 8'h00);
    wr_rd(8'hDA, 8'hFF, 8'h00);
    wr_rd(8'h8F, 8'hFF, 8'h00);
    check("resp", 32'h00000000, {31'h00000000, hresp});
    stop_test();
  end
endmodule
